//--- qpc_pkg.sv
// qpc_pkg: constants and carrier types for the quadrature position counter
// assumes a single 200 MHz clock domain; each clock is one instruction cycle
package qpc_pkg;

    // ------------------------------------------------------------
    // widths and reset values
    // ------------------------------------------------------------
    localparam int          COUNT_W       = 16;
    localparam int          BYTE_W        = 8;
    localparam int          MODE_W        = 3;
    localparam logic [15:0] COUNT_RST     = 16'h0000;
    localparam logic [15:0] COUNT_ZERO    = 16'h0000;
    localparam logic [15:0] COUNT_ALL_ONE = 16'hFFFF;
    localparam int          SYNC_STAGES   = 2;

    // ------------------------------------------------------------
    // mode select codes
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        QPC_MODE_OFF      = 3'b000,
        QPC_MODE_X2_INDEX = 3'b001,
        QPC_MODE_X2_MATCH = 3'b010,
        QPC_MODE_UNUSED3  = 3'b011,
        QPC_MODE_UNUSED4  = 3'b100,
        QPC_MODE_X4_INDEX = 3'b101,
        QPC_MODE_X4_MATCH = 3'b110,
        QPC_MODE_UNUSED7  = 3'b111
    } qpc_mode_t;

    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic phase_a_input;
        logic phase_b_input;
        logic index_input;
    } qpc_pins_t;

    typedef struct packed {
        logic position_event;
        logic count_error;
        logic direction_change;
    } qpc_events_t;

    typedef enum logic [1:0] {
        QPC_EDGE_A_RISE = 2'b00,
        QPC_EDGE_A_FALL = 2'b01,
        QPC_EDGE_B_RISE = 2'b10,
        QPC_EDGE_B_FALL = 2'b11
    } qpc_edge_t;

endpackage

//--- qpc_position_counter.sv
// qpc_position_counter: quadrature decoder, direction logic and 16-bit
// position counter with index or period-match reset
// assumes encoder pins are asynchronous; mode, limit and flag clears come
// from logic on i_clk
//
// Overview of operation
// R1: mode 000 disables decoding; no counting, no events.
// R2: 2x modes 001/010 count both edges of phase A only.
// R3: 4x modes 101/110 count both edges of phase A and phase B.
// R4: unused codes 011, 100, 111 behave like disabled.
// R5: modes 001/101 use the index input to reset the count.
// R6: modes 010/110 reset the count on match with the period limit.
// R7: direction flag 1 and count up when A leads B, else 0, down.
// R8: direction of each edge follows the previous opposite-phase edge.
// R9: every counted edge without a reset or limit load changes the count by exactly one.
// R10: index mode forward: clear count on first edge after index rise.
// R11: index mode reverse: load limit on first edge after index fall.
// R12: match mode forward: clear count on next edge once count equals limit.
// R13: position event one cycle after a forward match reset.
// R14: match mode reverse: load limit on next edge when count is zero.
// R15: position event one cycle after a reverse limit load.
// R16: count is kept unchanged across mode changes and while disabled.
// R17: count is readable as a high and low byte pair.
// R18: count and period limit are 16 bits, high and low bytes.
// R19: position event lasts one cycle; software clears the flag.
// R20: match modes also raise position event on FFFFh to 0000h rollover.
// R21: count error flag set on rollover in index mode.
// R22: direction change flag set two cycles after direction changes.
`timescale 1ns/1ps

module qpc_position_counter (
    // clock and reset
    input  wire logic                            i_clk,
    input  wire logic                            i_sys_rst,
    // encoder pins
    input  wire qpc_pkg::qpc_pins_t              i_pins,
    // configuration
    input  wire logic [qpc_pkg::MODE_W-1:0]      i_decoder_mode_select,
    input  wire logic [qpc_pkg::BYTE_W-1:0]      i_period_limit_high,
    input  wire logic [qpc_pkg::BYTE_W-1:0]      i_period_limit_low,
    // flag clears from software
    input  wire logic                            i_clear_position_event_flag,
    input  wire logic                            i_clear_count_error_flag,
    input  wire logic                            i_clear_direction_change_flag,
    // status
    output logic [qpc_pkg::BYTE_W-1:0]           o_position_count_high,
    output logic [qpc_pkg::BYTE_W-1:0]           o_position_count_low,
    output logic                                 o_direction,
    output qpc_pkg::qpc_events_t                 o_event_pulses,
    output logic                                 o_position_event_flag,
    output logic                                 o_count_error_flag,
    output logic                                 o_direction_change_flag
);

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    qpc_pkg::qpc_pins_t sync_meta;
    qpc_pkg::qpc_pins_t sync_pins;
    qpc_pkg::qpc_pins_t prev_pins;

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            sync_meta <= '0;
            sync_pins <= '0;
            prev_pins <= '0;
        end else begin
            sync_meta <= i_pins;
            sync_pins <= sync_meta;
            prev_pins <= sync_pins;
        end
    end

    // ------------------------------------------------------------
    // mode decode and edge detect
    // ------------------------------------------------------------
    qpc_pkg::qpc_mode_t mode;
    logic               mode_x2;
    logic               mode_x4;
    logic               enabled;
    logic               index_mode;
    logic               match_mode;
    logic               a_rise;
    logic               a_fall;
    logic               b_rise;
    logic               b_fall;
    logic               idx_rise;
    logic               idx_fall;
    logic               active_edge;
    logic [15:0]        period_limit;

    assign mode         = qpc_pkg::qpc_mode_t'(i_decoder_mode_select);
    assign mode_x2      = (mode == qpc_pkg::QPC_MODE_X2_INDEX)
                       || (mode == qpc_pkg::QPC_MODE_X2_MATCH);             // R2
    assign mode_x4      = (mode == qpc_pkg::QPC_MODE_X4_INDEX)
                       || (mode == qpc_pkg::QPC_MODE_X4_MATCH);             // R3
    // off and unused codes fall out here
    assign enabled      = mode_x2 || mode_x4;                               // R1 R4
    assign index_mode   = (mode == qpc_pkg::QPC_MODE_X2_INDEX)
                       || (mode == qpc_pkg::QPC_MODE_X4_INDEX);             // R5
    assign match_mode   = (mode == qpc_pkg::QPC_MODE_X2_MATCH)
                       || (mode == qpc_pkg::QPC_MODE_X4_MATCH);             // R6
    assign period_limit = {i_period_limit_high, i_period_limit_low};       // R18
    assign a_rise   = sync_pins.phase_a_input  && !prev_pins.phase_a_input;
    assign a_fall   = !sync_pins.phase_a_input && prev_pins.phase_a_input;
    assign b_rise   = sync_pins.phase_b_input  && !prev_pins.phase_b_input;
    assign b_fall   = !sync_pins.phase_b_input && prev_pins.phase_b_input;
    assign idx_rise = sync_pins.index_input    && !prev_pins.index_input;
    assign idx_fall = !sync_pins.index_input   && prev_pins.index_input;
    assign active_edge = enabled && ((a_rise || a_fall)
                       || (mode_x4 && (b_rise || b_fall)));                 // R2 R3

    // ------------------------------------------------------------
    // direction decode
    // ------------------------------------------------------------
    // last edge seen on each phase, kept in every mode so the first
    // edge after enabling already has a reference
    logic last_a_rise;
    logic last_b_rise;
    logic next_last_a_rise;
    logic next_last_b_rise;
    logic direction;
    logic next_direction;
    logic edge_up;

    always_comb begin
        next_last_a_rise = last_a_rise;
        next_last_b_rise = last_b_rise;
        next_direction   = direction;
        edge_up          = direction;
        if (a_rise) begin
            edge_up = !last_b_rise;                                         // R8
        end else if (a_fall) begin
            edge_up = last_b_rise;                                          // R8
        end else if (b_rise) begin
            edge_up = last_a_rise;                                          // R8
        end else if (b_fall) begin
            edge_up = !last_a_rise;                                         // R8
        end
        if (a_rise || a_fall) begin
            next_last_a_rise = a_rise;
        end
        if (b_rise || b_fall) begin
            next_last_b_rise = b_rise;
        end
        if (active_edge) begin
            next_direction = edge_up;                                       // R7
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            last_a_rise <= 1'b0;
            last_b_rise <= 1'b0;
            direction   <= 1'b0;
        end else begin
            last_a_rise <= next_last_a_rise;
            last_b_rise <= next_last_b_rise;
            direction   <= next_direction;
        end
    end

    // ------------------------------------------------------------
    // position counter and reset events
    // ------------------------------------------------------------
    logic [15:0] position_count;
    logic [15:0] next_position_count;
    logic        index_armed_fwd;
    logic        index_armed_rev;
    logic        next_index_armed_fwd;
    logic        next_index_armed_rev;
    logic        pos_event_due;
    logic        next_pos_event_due;
    logic        rollover;

    always_comb begin
        next_position_count  = position_count;                              // R16
        next_index_armed_fwd = index_armed_fwd;
        next_index_armed_rev = index_armed_rev;
        next_pos_event_due   = 1'b0;
        rollover             = 1'b0;
        if (!index_mode) begin
            next_index_armed_fwd = 1'b0;
            next_index_armed_rev = 1'b0;
        end else begin
            if (idx_rise) begin
                next_index_armed_fwd = 1'b1;                                // R10
            end
            if (idx_fall) begin
                next_index_armed_rev = 1'b1;                                // R11
            end
        end
        if (active_edge) begin
            if (index_mode && edge_up && index_armed_fwd) begin
                next_position_count  = qpc_pkg::COUNT_ZERO;                 // R10
                next_index_armed_fwd = 1'b0;
                next_index_armed_rev = 1'b0;
                next_pos_event_due   = 1'b1;
            end else if (index_mode && !edge_up && index_armed_rev) begin
                next_position_count  = period_limit;                        // R11
                next_index_armed_fwd = 1'b0;
                next_index_armed_rev = 1'b0;
                next_pos_event_due   = 1'b1;
            end else if (match_mode && edge_up && position_count == period_limit) begin
                next_position_count = qpc_pkg::COUNT_ZERO;                  // R12
                next_pos_event_due  = 1'b1;                                 // R13
            end else if (match_mode && !edge_up
                         && position_count == qpc_pkg::COUNT_ZERO) begin
                next_position_count = period_limit;                         // R14
                next_pos_event_due  = 1'b1;                                 // R15
            end else if (edge_up) begin
                next_position_count = position_count + 16'h0001;            // R9
                rollover = (position_count == qpc_pkg::COUNT_ALL_ONE);
            end else begin
                next_position_count = position_count - 16'h0001;            // R9
                rollover = (position_count == qpc_pkg::COUNT_ZERO);
            end
            if (match_mode && edge_up
                && position_count == qpc_pkg::COUNT_ALL_ONE) begin
                next_pos_event_due = 1'b1;                                  // R20
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            position_count  <= qpc_pkg::COUNT_RST;
            index_armed_fwd <= 1'b0;
            index_armed_rev <= 1'b0;
            pos_event_due   <= 1'b0;
        end else begin
            position_count  <= next_position_count;
            index_armed_fwd <= next_index_armed_fwd;
            index_armed_rev <= next_index_armed_rev;
            pos_event_due   <= next_pos_event_due;
        end
    end

    // ------------------------------------------------------------
    // event pulses and sticky flags
    // ------------------------------------------------------------
    logic                 dir_seen;
    logic                 next_dir_seen;
    logic                 dir_prev;
    logic                 next_dir_prev;
    qpc_pkg::qpc_events_t pulses;
    qpc_pkg::qpc_events_t next_pulses;
    logic                 pos_flag;
    logic                 err_flag;
    logic                 dchg_flag;
    logic                 next_pos_flag;
    logic                 next_err_flag;
    logic                 next_dchg_flag;

    always_comb begin
        next_dir_prev = direction;
        next_dir_seen = dir_seen || enabled;
        // one-cycle pulses; position event sits one cycle after the count update, count error in the same cycle as it
        next_pulses.position_event   = pos_event_due;                       // R13 R15 R19
        next_pulses.count_error      = rollover && index_mode;              // R21
        next_pulses.direction_change = dir_seen && (direction != dir_prev); // R22
        // set wins over a clear in the same cycle
        next_pos_flag  = pulses.position_event
                      || (pos_flag && !i_clear_position_event_flag);        // R19
        next_err_flag  = pulses.count_error
                      || (err_flag && !i_clear_count_error_flag);           // R21
        next_dchg_flag = pulses.direction_change
                      || (dchg_flag && !i_clear_direction_change_flag);     // R22
    end

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            dir_prev  <= 1'b0;
            dir_seen  <= 1'b0;
            pulses    <= '0;
            pos_flag  <= 1'b0;
            err_flag  <= 1'b0;
            dchg_flag <= 1'b0;
        end else begin
            dir_prev  <= next_dir_prev;
            dir_seen  <= next_dir_seen;
            pulses    <= next_pulses;
            pos_flag  <= next_pos_flag;
            err_flag  <= next_err_flag;
            dchg_flag <= next_dchg_flag;
        end
    end

    assign o_position_count_high   = position_count[15:8];                 // R17
    assign o_position_count_low    = position_count[7:0];                  // R17
    assign o_direction             = direction;
    assign o_event_pulses          = pulses;
    assign o_position_event_flag   = pos_flag;
    assign o_count_error_flag      = err_flag;
    assign o_direction_change_flag = dchg_flag;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    sequence s_match_fwd;
        match_mode && active_edge && edge_up && position_count == period_limit;
    endsequence

    sequence s_event_after;
        ##1 position_count == qpc_pkg::COUNT_ZERO ##1 pulses.position_event;
    endsequence

    a_disabled_hold: assert property (@(posedge i_clk) disable iff (i_sys_rst) // R1
        !enabled |=> $stable(position_count))
        else $error("count moved while decoder disabled");

    a_x2_ignores_b: assert property (@(posedge i_clk) disable iff (i_sys_rst) // R2
        mode_x2 && !(a_rise || a_fall) |=> $stable(position_count))
        else $error("count moved without phase A edge in 2x mode");

    a_x4_counts_b: assert property (@(posedge i_clk) disable iff (i_sys_rst) // R3
        mode_x4 && (b_rise || b_fall) |=> !$stable(position_count)
        || position_count == period_limit || position_count == qpc_pkg::COUNT_ZERO)
        else $error("phase B edge not counted in 4x mode");

    a_step_one: assert property (@(posedge i_clk) disable iff (i_sys_rst) // R9
        active_edge && edge_up && !(index_mode && index_armed_fwd)
        && !(match_mode && position_count == period_limit)
        |=> position_count == $past(position_count) + 16'h0001)
        else $error("forward edge did not add exactly one");

    a_match_reset: assert property (@(posedge i_clk) disable iff (i_sys_rst) // R12
        s_match_fwd |-> s_event_after)
        else $error("forward match did not clear and signal");

    a_rev_load: assert property (@(posedge i_clk) disable iff (i_sys_rst) // R14
        match_mode && active_edge && !edge_up && position_count == qpc_pkg::COUNT_ZERO
        |=> position_count == $past(period_limit) ##1 pulses.position_event)
        else $error("reverse match did not load limit");

    a_pulse_single: assert property (@(posedge i_clk) disable iff (i_sys_rst) // R19
        pulses.position_event |=> !pulses.position_event)
        else $error("position event longer than one cycle");

    a_flag_sticky: assert property (@(posedge i_clk) disable iff (i_sys_rst) // R19
        pos_flag && !i_clear_position_event_flag |=> pos_flag)
        else $error("position flag dropped without clear");

    a_index_fwd: assert property (@(posedge i_clk) disable iff (i_sys_rst) // R10
        index_mode && active_edge && edge_up && index_armed_fwd
        |=> position_count == qpc_pkg::COUNT_ZERO)
        else $error("index forward reset missed");

    a_dir_change: assert property (@(posedge i_clk) disable iff (i_sys_rst) // R22
        dir_seen && $changed(direction) |=> pulses.direction_change ##1 dchg_flag)
        else $error("direction change not flagged");

endmodule

//--- qpc_encoder_model.sv
// qpc_encoder_model: behavioural two-phase encoder with index for the bench
// assumes the bench calls step and set_index, and waits out the sync delay
`timescale 1ns/1ps

module qpc_encoder_model (
    // clock
    input  wire logic          i_clk,
    // encoder pins
    output qpc_pkg::qpc_pins_t o_pins
);
    int unsigned phase       = 0;
    logic        index_level = 1'b0;

    // ------------------------------------------------------------
    // pins
    // ------------------------------------------------------------
    // forward order 00,10,11,01 so phase a leads phase b
    assign o_pins.phase_a_input = (phase == 1) || (phase == 2);
    assign o_pins.phase_b_input = (phase == 2) || (phase == 3);
    assign o_pins.index_input   = index_level;

    // one pin changes per step, on the falling edge
    task automatic step(input bit fwd);
        @(negedge i_clk);
        phase = fwd ? (phase + 1) % 4 : (phase + 3) % 4;
    endtask

    task automatic set_index(input logic v);
        @(negedge i_clk);
        index_level = v;
    endtask
endmodule

//--- quadrature_position_counter_tb.sv
// quadrature_position_counter_tb: walks every mode code against a model
// assumes the 3-cycle pin latency and 5-cycle flag latency (4 for the error flag) of the design
`timescale 1ns/1ps

module quadrature_position_counter_tb;
    logic                 i_clk = 1'b0;
    logic                 i_sys_rst = 1'b1;
    qpc_pkg::qpc_pins_t   pins;
    logic [2:0]           mode = 3'h0;
    logic [7:0]           lim_h = 8'h00;
    logic [7:0]           lim_l = 8'h00;
    logic                 clr = 1'b0;
    logic [7:0]           cnt_h;
    logic [7:0]           cnt_l;
    logic                 dir;
    qpc_pkg::qpc_events_t pulses;
    logic                 flag_p;
    logic                 flag_e;
    logic                 flag_d;
    int                   mismatches = 0;
    int                   checked = 0;
    int                   exp_cnt = 0;
    int                   exp_lim = 0;
    int                   ev_model = 0;
    int                   ev_seen = 0;
    int                   err_model = 0;
    int                   err_seen = 0;
    int                   dchg_model = 0;
    int                   dchg_seen = 0;
    bit                   exp_dir, exp_fp, exp_fe, exp_fd, arm_f, arm_r;

    always #2.5 i_clk = ~i_clk;

    qpc_encoder_model i_enc (.i_clk(i_clk), .o_pins(pins));

    qpc_position_counter i_dut (
        .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_pins(pins),
        .i_decoder_mode_select(mode),
        .i_period_limit_high(lim_h), .i_period_limit_low(lim_l),
        .i_clear_position_event_flag(clr), .i_clear_count_error_flag(clr),
        .i_clear_direction_change_flag(clr),
        .o_position_count_high(cnt_h), .o_position_count_low(cnt_l),
        .o_direction(dir), .o_event_pulses(pulses),
        .o_position_event_flag(flag_p), .o_count_error_flag(flag_e),
        .o_direction_change_flag(flag_d));

    // a pulse longer than one cycle is counted twice; sampled mid-cycle
    always @(negedge i_clk) begin
        if (!i_sys_rst && pulses.position_event === 1'b1) ev_seen++;
        if (!i_sys_rst && pulses.count_error === 1'b1) err_seen++;
        if (!i_sys_rst && pulses.direction_change === 1'b1) dchg_seen++;
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    task automatic chk(input logic [15:0] got, input logic [15:0] want, input string what);
        checked++;
        if (got !== want) begin
            mismatches++;
            $display("wrong value at %0t: %s got %h want %h", $time, what, got, want);
        end
    endtask

    task automatic tally_and_finish();
        $display("comparisons %0d, mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    // waits out sync, count update and flag latency, then clears flags
    task automatic settle(input bit act);
        repeat (7) @(posedge i_clk);
        @(negedge i_clk);
        chk({cnt_h, cnt_l}, exp_cnt[15:0], "count");
        if (act) chk({15'h0, dir}, {15'h0, exp_dir}, "direction");
        chk({15'h0, flag_p}, {15'h0, exp_fp}, "position flag");
        chk({15'h0, flag_e}, {15'h0, exp_fe}, "error flag");
        // direction only moves on counted edges, so every mode is judged
        chk({15'h0, flag_d}, {15'h0, exp_fd}, "dir flag");
        clr = 1'b1;
        @(negedge i_clk);
        clr = 1'b0;
        {exp_fp, exp_fe, exp_fd} = 3'h0;
    endtask

    task automatic pos_event();
        exp_fp = 1'b1;
        ev_model++;
    endtask

    task automatic do_step(input bit fwd);
        bit a_edge;
        bit act;
        a_edge = fwd ? (i_enc.phase % 2 == 0) : (i_enc.phase % 2 == 1);
        act = (mode inside {3'h1, 3'h2, 3'h5, 3'h6}) && (mode[2] || a_edge);
        i_enc.step(fwd);
        if (act) begin
            if (exp_dir != fwd) begin
                exp_fd = 1'b1;
                dchg_model++;
            end
            exp_dir = fwd;
            if (!mode[1]) begin
                if (fwd && arm_f) begin
                    exp_cnt = 0;
                    {arm_f, arm_r} = 2'h0;
                    pos_event();
                end else if (!fwd && arm_r) begin
                    exp_cnt = exp_lim;
                    {arm_f, arm_r} = 2'h0;
                    pos_event();
                end else begin
                    if ((fwd && exp_cnt == 65535) || (!fwd && exp_cnt == 0)) begin
                        exp_fe = 1'b1;
                        err_model++;
                    end
                    exp_cnt = (exp_cnt + (fwd ? 1 : 65535)) % 65536;
                end
            end else if (fwd && exp_cnt == exp_lim) begin
                exp_cnt = 0;
                pos_event();
            end else if (!fwd && exp_cnt == 0) begin
                exp_cnt = exp_lim;
                pos_event();
            end else begin
                if (fwd && exp_cnt == 65535) pos_event();
                exp_cnt = (exp_cnt + (fwd ? 1 : 65535)) % 65536;
            end
        end
        settle(act);
    endtask

    task automatic set_idx(input logic v);
        i_enc.set_index(v);
        if (!mode[1] && mode[0]) begin
            arm_f |= v;
            arm_r |= !v;
        end
        settle(1'b0);
    endtask

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        void'($urandom(32'h15DA));
        {exp_dir, exp_fp, exp_fe, exp_fd, arm_f, arm_r} = 6'h0;
        repeat (5) @(posedge i_clk);
        @(negedge i_clk);
        i_sys_rst = 1'b0;
        settle(1'b1);
        for (int m = 0; m < 8; m++) begin
            mode = m[2:0];
            exp_lim = $urandom % 8 + 3;
            {lim_h, lim_l} = exp_lim[15:0];
            if (!(m == 1 || m == 5)) {arm_f, arm_r} = 2'h0;
            repeat (3) @(negedge i_clk);
            repeat (8) do_step(1'b1);
            set_idx(1'b1);
            repeat (4) do_step(1'b1);
            set_idx(1'b0);
            repeat (14) do_step(1'b0);
            repeat (20) do_step($urandom % 2);
        end
        chk(ev_seen[15:0], ev_model[15:0], "position pulses");
        chk(err_seen[15:0], err_model[15:0], "error pulses");
        chk(dchg_seen[15:0], dchg_model[15:0], "dir pulses");
        tally_and_finish();
    end

    initial begin
        repeat (100000) @(posedge i_clk);
        mismatches++;
        tally_and_finish();
    end
endmodule
